// [logic/uvfr_fault_response.sv]
// Overview of operation
// - Undervoltage is only detected once power-good is asserted.
// - Action 10 disables output on undervoltage; retry 000 latches off.
// - Retry 001-111 restarts forever until disabled, bias lost or other fault.
// - Delay from fault to restart is (delay field + 1) times 35 ms.
// - Turn-on delay is applied again before each retry ramp.
// - Peak current above warning threshold sets the current warning bit.
// - Threshold writes outside 0 A to 100 A are refused, old value kept.
module uvfr_fault_response
  import uvfr_pkg::*;
#(
  parameter int RETRY_STEP = RETRY_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdWrData,
  output logic [15:0] cmdRdData,
  output logic cmdAck,
  output logic cmdNack,
  input wire logic enablePin,
  input wire logic powerGoodPin,
  input wire logic uvComparePin,
  input wire logic operationOn,
  input wire logic biasPowerOk,
  input wire logic otherFaultOff,
  input wire logic [31:0] tonDelayCycles,
  input wire logic [15:0] peakCurrent,
  input wire logic peakCurrentValid,
  output logic outputEnable,
  output logic alertLineN
);

  // Elaboration check: eight steps must still fit the 32-bit counter
  if (RETRY_STEP < 1 || RETRY_STEP > 32'h1FFFFFFF / 8) begin : g_bad_step
    $error("RETRY_STEP out of range");
  end

  // Pin synchronisers: first stage feeds only the second
  logic [SYNC_STAGES-1:0] enSync_reg, pgSync_reg, uvSync_reg;
  logic enFilt_reg, pgFilt_reg, uvFilt_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enSync_reg <= '0;
      pgSync_reg <= '0;
      uvSync_reg <= '0;
    end else begin
      enSync_reg <= {enSync_reg[1:0], enablePin};
      pgSync_reg <= {pgSync_reg[1:0], powerGoodPin};
      uvSync_reg <= {uvSync_reg[1:0], uvComparePin};
    end
  end

  // A level counts once the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enFilt_reg <= 1'b0;
      pgFilt_reg <= 1'b0;
      uvFilt_reg <= 1'b0;
    end else begin
      if (enSync_reg[1] == enSync_reg[2]) enFilt_reg <= enSync_reg[2];
      if (pgSync_reg[1] == pgSync_reg[2]) pgFilt_reg <= pgSync_reg[2];
      if (uvSync_reg[1] == uvSync_reg[2]) uvFilt_reg <= uvSync_reg[2];
    end
  end

  // Configuration, status and sequencer registers
  logic [7:0] uvResponse_reg;
  logic [15:0] ocWarn_reg;
  logic uvFlag_reg, ocwFlag_reg;
  uvfr_state_e state_reg, state_next;
  logic [31:0] count_reg, count_next;

  // Command decode
  wire wrStrobe = cmdValid && cmdWrite;
  wire rdStrobe = cmdValid && !cmdWrite;
  wire wrUvResp = wrStrobe && (cmdCode == CMD_UV_RESPONSE);
  wire wrOcWarn = wrStrobe && (cmdCode == CMD_OC_WARN);
  wire ocWarnOk = uvfrOcWarnInRange(cmdWrData);
  wire clearCmd = wrStrobe && (cmdCode == CMD_CLEAR_FAULTS);
  wire rdKnown = (cmdCode == CMD_UV_RESPONSE) || (cmdCode == CMD_OC_WARN) ||
                 (cmdCode == CMD_STATUS_VOUT) || (cmdCode == CMD_STATUS_IOUT);
  wire cmdGood = (rdStrobe && rdKnown) || wrUvResp || clearCmd ||
                 (wrOcWarn && ocWarnOk);

  // Response fields
  wire [1:0] action = uvResponse_reg[ACT_MSB:ACT_LSB];
  wire [2:0] retries = uvResponse_reg[RETRY_MSB:RETRY_LSB];
  wire [2:0] delayCode = uvResponse_reg[DELAY_MSB:DELAY_LSB];
  wire [31:0] retryCycles = 32'({29'h0, delayCode} + 32'h1) *
                            32'(RETRY_STEP);
  wire [31:0] tonLoad = (tonDelayCycles == 32'h0) ? 32'h1 : tonDelayCycles;

  // Unit may run only while enabled, biased and free of other faults
  wire runAllowed = enFilt_reg && operationOn && biasPowerOk &&
                    !otherFaultOff;
  // Masked during ramp and before power-good
  wire uvEvent = (state_reg == ST_RUN) && pgFilt_reg && uvFilt_reg;
  wire uvDisable = uvEvent && (action == ACT_DISABLE_RETRY);
  // Warning compare in the same fixed point scale
  wire signed [47:0] ocThresh = uvfrLin11ToFixed(ocWarn_reg);
  wire ocwEvent = peakCurrentValid &&
                  (48'(peakCurrent) > ocThresh);

  // Register writes; an out-of-range threshold leaves the old value
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      uvResponse_reg <= UV_RESPONSE_RESET;
      ocWarn_reg <= OC_WARN_RESET;
    end else begin
      if (wrUvResp) uvResponse_reg <= cmdWrData[7:0];
      if (wrOcWarn && ocWarnOk) ocWarn_reg <= cmdWrData;
    end
  end

  // Sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      uvFlag_reg <= 1'b0;
      ocwFlag_reg <= 1'b0;
    end else begin
      uvFlag_reg <= uvEvent || (uvFlag_reg && !clearCmd);
      ocwFlag_reg <= ocwEvent || (ocwFlag_reg && !clearCmd);
    end
  end

  // Output sequencing; counter holds the remaining cycles of a wait
  always_comb begin
    state_next = state_reg;
    count_next = (count_reg > 32'h1) ? count_reg - 32'h1 : count_reg;
    case (state_reg)
      ST_OFF: begin
        if (runAllowed) begin
          state_next = ST_TON;
          count_next = tonLoad;
        end
      end
      ST_TON: begin
        if (count_reg == 32'h1) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (uvDisable && retries == RETRY_NONE) begin
          state_next = ST_LATCH;
        end else if (uvDisable) begin
          state_next = ST_RETRY;
          count_next = retryCycles;
        end
      end
      ST_RETRY: begin
        if (count_reg == 32'h1) begin
          state_next = ST_TON;
          count_next = tonLoad;
        end
      end
      ST_LATCH: begin
        if (clearCmd) state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
    // Stop conditions end every attempt; a latch waits for clear-faults
    if (!runAllowed && state_reg != ST_LATCH) begin
      state_next = ST_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_OFF;
      count_reg <= 32'h1;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Read mux; unknown codes read as zero and are refused
  wire [15:0] statusVout = 16'(uvFlag_reg) << STATUS_VOUT_UV_BIT;
  wire [15:0] statusIout = 16'(ocwFlag_reg) << STATUS_IOUT_OCW_BIT;
  wire [15:0] rdMux = (cmdCode == CMD_UV_RESPONSE) ? {8'h00, uvResponse_reg} :
                      (cmdCode == CMD_OC_WARN) ? ocWarn_reg :
                      (cmdCode == CMD_STATUS_VOUT) ? statusVout :
                      (cmdCode == CMD_STATUS_IOUT) ? statusIout : 16'h0000;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmdRdData <= 16'h0000;
      cmdAck <= 1'b0;
      cmdNack <= 1'b0;
      outputEnable <= 1'b0;
      alertLineN <= 1'b1;
    end else begin
      if (rdStrobe) cmdRdData <= rdMux;
      cmdAck <= cmdValid && cmdGood;
      cmdNack <= cmdValid && !cmdGood;
      outputEnable <= (state_next == ST_RUN);
      alertLineN <= !(uvFlag_reg || ocwFlag_reg || uvEvent);
    end
  end

  // Checks
  property p_uv_after_pg;
    @(posedge ref_clk) disable iff (reset)
    (!uvFlag_reg && !(pgFilt_reg && state_reg == ST_RUN)) |=> !uvFlag_reg;
  endproperty
  a_uv_after_pg: assert property (p_uv_after_pg) else $error("uv before pg");

  property p_latch_off;
    @(posedge ref_clk) disable iff (reset)
    (uvDisable && retries == RETRY_NONE && runAllowed) |=>
      state_reg == ST_LATCH && !outputEnable;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("no latch off");

  property p_retry_start;
    @(posedge ref_clk) disable iff (reset)
    (uvDisable && retries != RETRY_NONE && runAllowed) |=>
      state_reg == ST_RETRY && !outputEnable;
  endproperty
  a_retry_start: assert property (p_retry_start) else $error("no retry");

  property p_retry_load;
    @(posedge ref_clk) disable iff (reset)
    (state_reg == ST_RUN && state_next == ST_RETRY) |=>
      count_reg == 32'($past(32'(delayCode)) + 1) * 32'(RETRY_STEP);
  endproperty
  a_retry_load: assert property (p_retry_load) else $error("bad delay");

  property p_ton_again;
    @(posedge ref_clk) disable iff (reset)
    (state_reg == ST_RETRY && count_reg == 32'h1 && runAllowed) |=>
      state_reg == ST_TON && !outputEnable;
  endproperty
  a_ton_again: assert property (p_ton_again) else $error("ton skipped");

  property p_alert_hold;
    @(posedge ref_clk) disable iff (reset)
    (uvFlag_reg && !clearCmd) |=> uvFlag_reg && !alertLineN;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert lost");

  property p_oc_warn;
    @(posedge ref_clk) disable iff (reset)
    ocwEvent |=> ocwFlag_reg ##1 !alertLineN;
  endproperty
  a_oc_warn: assert property (p_oc_warn) else $error("warn missed");

  property p_reject;
    @(posedge ref_clk) disable iff (reset)
    (wrOcWarn && !ocWarnOk) |=> $stable(ocWarn_reg) && cmdNack;
  endproperty
  a_reject: assert property (p_reject) else $error("bad limit kept");

  property p_range;
    @(posedge ref_clk) disable iff (reset)
    ocThresh >= 48'sh0 && ocThresh <= 48'(OC_WARN_MAX_FIXED);
  endproperty
  a_range: assert property (p_range) else $error("limit out of range");

  c_latch: cover property (@(posedge ref_clk) state_reg == ST_LATCH);
  c_retry: cover property (@(posedge ref_clk)
    state_reg == ST_RETRY ##1 state_reg == ST_TON);
  c_warn: cover property (@(posedge ref_clk) ocwEvent);
  c_reject: cover property (@(posedge ref_clk) wrOcWarn && !ocWarnOk);
endmodule

// [logic/uvfr_pkg.sv]
package uvfr_pkg;
  // Command codes of the supervisor's register port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_UV_RESPONSE = 8'h45;
  localparam logic [7:0] CMD_OC_WARN = 8'h4A;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
  // Reset values
  localparam logic [7:0] UV_RESPONSE_RESET = 8'hB8;
  localparam logic [15:0] OC_WARN_RESET = 16'h005F; // 95 A, exponent 0
  // Undervoltage response field layout and codes
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] ACT_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  // Status bit positions
  localparam int STATUS_VOUT_UV_BIT = 4;
  localparam int STATUS_IOUT_OCW_BIT = 5;
  // Current scale: fixed point amps with four fraction bits
  localparam int CUR_FRAC_BITS = 4;
  localparam int OC_WARN_MAX_AMPS = 100;
  localparam int OC_WARN_MIN_AMPS = 0;
  localparam longint OC_WARN_MAX_FIXED = OC_WARN_MAX_AMPS * (1 << CUR_FRAC_BITS);
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RETRY_STEP_MS = 35;
  localparam int RETRY_STEP_CYCLES = RETRY_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_TON = 6'h02,
    ST_RUN = 6'h04,
    ST_RETRY = 6'h08,
    ST_LATCH = 6'h10,
    ST_SPARE = 6'h20
  } uvfr_state_e;

  // Linear-11 word to signed fixed point amps
  function automatic logic signed [47:0] uvfrLin11ToFixed(
    input logic [15:0] word
  );
    logic signed [4:0] expo;
    logic signed [47:0] mant;
    int sh;
    expo = signed'(word[15:11]);
    mant = 48'(signed'(word[10:0]));
    sh = int'(expo) + CUR_FRAC_BITS;
    if (sh >= 0) begin
      return mant <<< sh;
    end
    return mant >>> (-sh);
  endfunction

  // Accepted threshold window, both ends inclusive
  function automatic logic uvfrOcWarnInRange(input logic [15:0] word);
    logic signed [47:0] v;
    v = uvfrLin11ToFixed(word);
    return (v >= 48'(OC_WARN_MIN_AMPS)) && (v <= 48'(OC_WARN_MAX_FIXED));
  endfunction
endpackage

// [tb/uvfr_host_model.sv]
module uvfr_host_model (
  input wire logic ref_clk,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdWrData,
  input wire logic [15:0] cmdRdData,
  input wire logic cmdAck,
  input wire logic cmdNack
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle port; data is inverted after use so stale words never match
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWrData = 16'hFFFF;
  end
  // One command pulse; the answer is taken while it stands, a cycle later
  // Caller keeps warning limit under fault limit and uses 80h as needed
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic a, output logic [15:0] r);
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode = c;
    cmdWrData = d;
    @(negedge ref_clk);
    a = cmdAck & ~cmdNack;
    r = cmdRdData;
    cmdValid = 1'b0;
    cmdWrData = ~d;
  endtask
endmodule

// [tb/testbench.sv]
module testbench
  import uvfr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic w;
    logic [7:0] c;
    logic [15:0] d;
    logic ack;
    logic [15:0] rd;
  } uvfrRow_s;
  logic ref_clk, reset, cmdValid, cmdWrite, cmdAck, cmdNack, en, pg, uv;
  logic opOn, bias, othOff, pkValid, oe, alertN, a;
  logic [7:0] cmdCode;
  logic [15:0] wrData, rdData, pk, r;
  int errTotal, checkCount, cyc;
  uvfrRow_s rows [12] = '{
    {1'b0, CMD_UV_RESPONSE, 16'h0000, 1'b1, 16'h00B8},
    {1'b0, CMD_OC_WARN, 16'h0000, 1'b1, 16'h005F},
    {1'b1, CMD_OC_WARN, 16'h0064, 1'b1, 16'h0000},
    {1'b0, CMD_OC_WARN, 16'h0000, 1'b1, 16'h0064},
    {1'b1, CMD_OC_WARN, 16'h0065, 1'b0, 16'h0000},
    {1'b1, CMD_OC_WARN, 16'h07FF, 1'b0, 16'h0000},
    {1'b1, CMD_OC_WARN, 16'hF8CA, 1'b0, 16'h0000},
    {1'b1, CMD_OC_WARN, 16'hF8C8, 1'b1, 16'h0000},
    {1'b0, CMD_OC_WARN, 16'h0000, 1'b1, 16'hF8C8},
    {1'b1, CMD_STATUS_VOUT, 16'h0000, 1'b0, 16'h0000},
    {1'b0, 8'h55, 16'h0000, 1'b0, 16'h0000},
    {1'b0, CMD_CLEAR_FAULTS, 16'h0000, 1'b0, 16'h0000}};
  // Short retry step keeps the delay tests to tens of cycles
  uvfr_fault_response #(.RETRY_STEP(4)) DUT (.ref_clk(ref_clk),
    .reset(reset), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdWrData(wrData), .cmdRdData(rdData),
    .cmdAck(cmdAck), .cmdNack(cmdNack), .enablePin(en),
    .powerGoodPin(pg), .uvComparePin(uv), .operationOn(opOn),
    .biasPowerOk(bias), .otherFaultOff(othOff), .tonDelayCycles(32'd5),
    .peakCurrent(pk), .peakCurrentValid(pkValid), .outputEnable(oe),
    .alertLineN(alertN));
  uvfr_host_model HOST (.ref_clk(ref_clk), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(wrData),
    .cmdRdData(rdData), .cmdAck(cmdAck), .cmdNack(cmdNack));
  // Clock at 20 MHz
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(logic w, logic [7:0] c, logic [15:0] d);
    HOST.xfer(w, c, d, a, r);
  endtask
  // Bounded wait for the output stage, cycles counted in cyc
  task automatic waitOe(logic lvl);
    cyc = 0;
    while (oe !== lvl && cyc < 300) begin
      @(negedge ref_clk);
      cyc++;
    end
    check("outputEnable", 16'(oe), 16'(lvl));
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    finishTest();
  end
  initial begin
    {reset, en, opOn, bias} = 4'hF;
    {othOff, pg, uv, pkValid} = 4'h0;
    pk = 16'h0000;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    check("reset oe", 16'(oe), 16'h0000);
    check("reset alert", 16'(alertN), 16'h0001);
    foreach (rows[i]) begin
      cmd(rows[i].w, rows[i].c, rows[i].d);
      check("ack", 16'(a), 16'(rows[i].ack));
      if (!rows[i].w) check("rdData", r, rows[i].rd);
    end
    $display("register table done");
    waitOe(1'b1);
    uv = 1'b1;
    repeat (20) @(negedge ref_clk);
    check("uv before pg", 16'(oe), 16'h0001);
    cmd(1'b0, CMD_STATUS_VOUT, 16'h0000);
    check("uv flag before pg", r, 16'h0000);
    {uv, pg} = 2'b01;
    repeat (5) @(negedge ref_clk);
    $display("power-good mask done");
    for (int d = 0; d < 8; d += 7) begin
      cmd(1'b1, CMD_UV_RESPONSE, 16'(8'h88 | d));
      uv = 1'b1;
      waitOe(1'b0);
      uv = 1'b0;
      check("alert", 16'(alertN), 16'h0000);
      waitOe(1'b1);
      check("gap ok", 16'(cyc >= (d + 1) * 4 + 4 && cyc <= (d + 1) * 4 + 7),
        16'h0001);
      cmd(1'b0, CMD_STATUS_VOUT, 16'h0000);
      check("uv flag", r, 16'h0010);
      cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
      // Alert follows the flag one cycle later
      @(negedge ref_clk);
      check("alert clear", 16'(alertN), 16'h0001);
    end
    $display("retry delay done");
    cmd(1'b1, CMD_UV_RESPONSE, 16'h0080);
    uv = 1'b1;
    waitOe(1'b0);
    uv = 1'b0;
    repeat (60) @(negedge ref_clk);
    check("latched off", 16'(oe), 16'h0000);
    cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    waitOe(1'b1);
    check("restart after clear", 16'(cyc <= 12), 16'h0001);
    $display("latch off done");
    cmd(1'b1, CMD_UV_RESPONSE, 16'h00BF);
    uv = 1'b1;
    waitOe(1'b0);
    {uv, othOff} = 2'b01;
    repeat (60) @(negedge ref_clk);
    check("retry stopped", 16'(oe), 16'h0000);
    othOff = 1'b0;
    cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    waitOe(1'b1);
    $display("retry stop done");
    cmd(1'b1, CMD_OC_WARN, 16'h0014);
    for (int k = 0; k < 2; k++) begin
      pk = 16'h0140 + 16'(k);
      pkValid = 1'b1;
      @(negedge ref_clk);
      pkValid = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("warn alert", 16'(alertN), 16'(k == 0));
      cmd(1'b0, CMD_STATUS_IOUT, 16'h0000);
      check("warn flag", r, k ? 16'h0020 : 16'h0000);
    end
    cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    cmd(1'b0, CMD_STATUS_IOUT, 16'h0000);
    check("warn cleared", r, 16'h0000);
    $display("current warning done");
    // Mid-run reset must restore outputs and both registers
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    check("mid reset oe", 16'(oe), 16'h0000);
    check("mid reset alert", 16'(alertN), 16'h0001);
    cmd(1'b0, CMD_UV_RESPONSE, 16'h0000);
    check("mid reset uv", r, 16'(UV_RESPONSE_RESET));
    cmd(1'b0, CMD_OC_WARN, 16'h0000);
    check("mid reset limit", r, OC_WARN_RESET);
    $display("mid-run reset done");
    finishTest();
  end
endmodule
